// file: hdl/dlp_pkg.sv
package dlp_pkg;

    // ------------------------------------------------------------
    // memory timing, ns (init in us) and derived cycles at the core clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_REFI_NS = 7800;
    localparam int T_RFC_NS = 110;
    localparam int T_XP_NS = 6;
    localparam int T_CKE_NS = 5;
    localparam int T_XS_NS = 120;
    localparam int T_INIT_US = 200;
    // longest interval and init time round down, other least times round up, none below one
    localparam int REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;
    localparam int RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XP_CYC = (T_XP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_CYC = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XS_CYC = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYC = (T_INIT_US * 1000) / CLK_PERIOD_NS;
    localparam int RD_TIMEOUT_CYC = 64;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // command encodings {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_DESEL = 4'hF;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;

    // ------------------------------------------------------------
    // controller states, gray along init -> idle -> power-down path
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_INIT_CKE = 4'h1,
        ST_IDLE = 4'h3,
        ST_PD_ENTER = 4'h2,
        ST_PD = 4'h6,
        ST_PD_EXIT = 4'h7,
        ST_REF = 4'h5,
        ST_REF_WAIT = 4'h4,
        ST_SR_ENTER = 4'hC,
        ST_SR = 4'hD,
        ST_SR_EXIT = 4'hF,
        ST_WR0 = 4'hE,
        ST_WR1 = 4'hA,
        ST_RD = 4'hB,
        ST_RD_WAIT = 4'h9
    } dlp_state_t;

endpackage

// file: hdl/dlp_ctrl.sv
// Overview of operation
// - low-power request/ack pairs active only when their build option is set
// - power-down request enters power-down once timing allows, then acknowledges
// - held power-down wakes memory periodically for auto-refresh, then re-enters
// - power-down request drop exits power-down; ack falls after exit completes
// - self-refresh request enters self-refresh once timing allows, then acknowledges
// - self-refresh request drop exits; ack falls after memory left the state
// - each low-power ack moves only in response to its own request; refresh ack follows the refresh timer
// - memory data bus is half the local width, two beats per word
// - byte mask outputs exclude bytes during writes
// - strobe pair accompanies write data and captures read data
// - every auto-refresh pulses refresh ack for exactly one cycle; self-refresh entry gives no pulse
`timescale 1ns/1ns
`default_nettype none

module dlp_ctrl #(
    parameter int DQ_W = 16,
    parameter int ADDR_W = 13,
    parameter int BA_W = 3,
    parameter bit EN_PWRDN = 1'b1,
    parameter bit EN_SELF_RFSH = 1'b1,
    parameter int INIT_CYCLES = dlp_pkg::INIT_CYC,
    parameter int REFI_CYCLES = dlp_pkg::REFI_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // local request side
    input wire logic i_read_req,
    input wire logic i_write_req,
    input wire logic [ADDR_W+BA_W-1:0] i_addr,
    input wire logic [2*DQ_W-1:0] i_wdata,
    input wire logic [DQ_W/4-1:0] i_be,
    output logic o_ready,
    output logic [2*DQ_W-1:0] o_rdata,
    output logic o_rdata_valid,
    output logic o_init_done,
    output logic o_refresh_ack,
    // low-power handshakes
    input wire logic i_powerdn_req,
    output logic o_powerdn_ack,
    input wire logic i_self_rfsh_req,
    output logic o_self_rfsh_ack,
    // memory pins
    output logic o_dram_clk,
    output logic o_dram_clk_n,
    output logic o_dram_cke,
    output logic o_dram_cs_n,
    output logic o_dram_ras_n,
    output logic o_dram_cas_n,
    output logic o_dram_we_n,
    output logic [ADDR_W-1:0] o_dram_a,
    output logic [BA_W-1:0] o_dram_ba,
    output logic o_dram_odt,
    output logic o_dram_reset_n,
    output logic [DQ_W/8-1:0] o_dram_byte_mask,
    input wire logic [DQ_W-1:0] i_dram_dq,
    output logic [DQ_W-1:0] o_dram_dq,
    output logic o_dram_dq_oe_n,
    input wire logic i_dram_dqs,
    output logic o_dram_dqs,
    output logic o_dram_dqs_oe_n,
    input wire logic i_dram_dqs_n,
    output logic o_dram_dqs_n,
    output logic o_dram_dqs_n_oe_n
);

    localparam int BM_W = DQ_W / 8;

    // ------------
    // feature gating
    // ------------
    logic pd_req;
    logic sr_req;
    assign pd_req = EN_PWRDN ? i_powerdn_req : 1'b0;
    assign sr_req = EN_SELF_RFSH ? i_self_rfsh_req : 1'b0;

    // ------------
    // read pin synchronisers
    // ------------
    logic [DQ_W-1:0] dq_s1, dq_s2;
    logic dqs_s1, dqs_s2, dqs_s3;
    logic dqs_n_s1, dqs_n_s2;
    logic dqs_rise;
    logic [1:0] drv_hist, next_drv_hist;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dqs_s1 <= 1'b0;
            dqs_s2 <= 1'b0;
            dqs_s3 <= 1'b0;
            dqs_n_s1 <= 1'b1;
            dqs_n_s2 <= 1'b1;
        end else begin
            dq_s1 <= i_dram_dq;
            dq_s2 <= dq_s1;
            dqs_s1 <= i_dram_dqs;
            dqs_s2 <= dqs_s1;
            dqs_s3 <= dqs_s2;
            dqs_n_s1 <= i_dram_dqs_n;
            dqs_n_s2 <= dqs_n_s1;
        end
    end

    // strobe pair qualifies each read beat, never our own write echo
    assign dqs_rise = dqs_s2 & ~dqs_s3 & ~dqs_n_s2 & ~|drv_hist;

    // ------------
    // controller state
    // ------------
    dlp_pkg::dlp_state_t state, next_state;
    logic [dlp_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [dlp_pkg::CNT_W-1:0] refi_cnt, next_refi_cnt;
    logic [3:0] cmd, next_cmd;
    logic cke, next_cke;
    logic mem_rst_n, next_mem_rst_n;
    logic init_done, next_init_done;
    logic pd_ack, next_pd_ack;
    logic sr_ack, next_sr_ack;
    logic ref_ack, next_ref_ack;
    logic [ADDR_W+BA_W-1:0] addr, next_addr;
    logic [2*DQ_W-1:0] wdata, next_wdata;
    logic [DQ_W/4-1:0] be, next_be;
    logic [DQ_W-1:0] dq_out, next_dq_out;
    logic [BM_W-1:0] bmask, next_bmask;
    logic dq_oe_n, next_dq_oe_n;
    logic dqs_out, next_dqs_out;
    logic odt, next_odt;
    logic [2*DQ_W-1:0] rdata, next_rdata;
    logic rvalid, next_rvalid;
    logic rbeat, next_rbeat;
    logic mclk, next_mclk;
    logic ref_due;

    assign ref_due = (refi_cnt == '0);
    // requests only taken from idle with no low-power or refresh pending
    assign o_ready = (state == dlp_pkg::ST_IDLE) && !ref_due && !pd_req && !sr_req;

    always_comb begin
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_refi_cnt = ref_due ? refi_cnt : refi_cnt - 1'b1;
        next_cmd = dlp_pkg::CMD_NOP;
        next_cke = cke;
        next_mem_rst_n = mem_rst_n;
        next_init_done = init_done;
        next_pd_ack = pd_ack;
        next_sr_ack = sr_ack;
        next_ref_ack = 1'b0;
        next_addr = addr;
        next_wdata = wdata;
        next_be = be;
        next_dq_out = dq_out;
        next_bmask = {BM_W{1'b1}};
        next_dq_oe_n = 1'b1;
        next_dqs_out = 1'b0;
        next_odt = 1'b0;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        next_rbeat = rbeat;
        next_mclk = ~mclk;
        next_drv_hist = {drv_hist[0], ~dq_oe_n};
        case (state)
            dlp_pkg::ST_INIT: begin
                next_cmd = dlp_pkg::CMD_DESEL;
                if (cnt == '0) begin
                    next_mem_rst_n = 1'b1;
                    next_cke = 1'b1;
                    next_cnt = dlp_pkg::CNT_W'(dlp_pkg::XS_CYC);
                    next_state = dlp_pkg::ST_INIT_CKE;
                end
            end
            dlp_pkg::ST_INIT_CKE: begin
                if (cnt == '0) begin
                    next_init_done = 1'b1;
                    next_refi_cnt = dlp_pkg::CNT_W'(REFI_CYCLES);
                    next_state = dlp_pkg::ST_IDLE;
                end
            end
            dlp_pkg::ST_IDLE: begin
                if (ref_due) begin
                    next_state = dlp_pkg::ST_REF;
                end else if (sr_req) begin
                    // entry once no refresh is owed
                    next_cmd = dlp_pkg::CMD_REF;
                    next_cke = 1'b0;
                    next_cnt = dlp_pkg::CNT_W'(dlp_pkg::CKE_CYC);
                    next_state = dlp_pkg::ST_SR_ENTER;
                end else if (pd_req) begin
                    // entry once no refresh is owed
                    next_cke = 1'b0;
                    next_cnt = dlp_pkg::CNT_W'(dlp_pkg::CKE_CYC);
                    next_state = dlp_pkg::ST_PD_ENTER;
                end else if (i_write_req) begin
                    next_addr = i_addr;
                    next_wdata = i_wdata;
                    next_be = i_be;
                    next_cmd = dlp_pkg::CMD_WR;
                    next_odt = 1'b1;
                    next_state = dlp_pkg::ST_WR0;
                end else if (i_read_req) begin
                    next_addr = i_addr;
                    next_cmd = dlp_pkg::CMD_RD;
                    next_rbeat = 1'b0;
                    next_cnt = dlp_pkg::CNT_W'(dlp_pkg::RD_TIMEOUT_CYC);
                    next_state = dlp_pkg::ST_RD_WAIT;
                end
            end
            dlp_pkg::ST_WR0: begin
                // low half of the local word first
                next_dq_out = wdata[DQ_W-1:0];
                next_bmask = ~be[BM_W-1:0];
                next_dq_oe_n = 1'b0;
                next_dqs_out = 1'b1;
                next_odt = 1'b1;
                next_state = dlp_pkg::ST_WR1;
            end
            dlp_pkg::ST_WR1: begin
                next_dq_out = wdata[2*DQ_W-1:DQ_W];
                next_bmask = ~be[2*BM_W-1:BM_W];
                next_dq_oe_n = 1'b0;
                next_dqs_out = 1'b0;
                next_odt = 1'b1;
                next_state = dlp_pkg::ST_IDLE;
            end
            dlp_pkg::ST_RD_WAIT: begin
                // two strobed beats build one local word
                if (dqs_rise) begin
                    next_rbeat = 1'b1;
                    if (!rbeat) begin
                        next_rdata[DQ_W-1:0] = dq_s2;
                    end else begin
                        next_rdata[2*DQ_W-1:DQ_W] = dq_s2;
                        next_rvalid = 1'b1;
                        next_state = dlp_pkg::ST_IDLE;
                    end
                end else if (cnt == '0) begin
                    // lost strobe would otherwise hang the controller
                    next_state = dlp_pkg::ST_IDLE;
                end
            end
            dlp_pkg::ST_PD_ENTER: begin
                if (cnt == '0) begin
                    // ack rises only after the state is entered
                    next_pd_ack = 1'b1;
                    next_state = dlp_pkg::ST_PD;
                end
            end
            dlp_pkg::ST_PD: begin
                // wake for refresh; or leave on request drop
                if (ref_due || !pd_req) begin
                    next_cke = 1'b1;
                    next_cnt = dlp_pkg::CNT_W'(dlp_pkg::XP_CYC);
                    next_state = dlp_pkg::ST_PD_EXIT;
                end
            end
            dlp_pkg::ST_PD_EXIT: begin
                if (cnt == '0) begin
                    if (ref_due) begin
                        next_state = dlp_pkg::ST_REF;
                    end else begin
                        // ack falls once exit is complete
                        next_pd_ack = 1'b0;
                        next_state = dlp_pkg::ST_IDLE;
                    end
                end
            end
            dlp_pkg::ST_REF: begin
                next_cmd = dlp_pkg::CMD_REF;
                next_ref_ack = 1'b1;
                next_refi_cnt = dlp_pkg::CNT_W'(REFI_CYCLES);
                next_cnt = dlp_pkg::CNT_W'(dlp_pkg::RFC_CYC);
                next_state = dlp_pkg::ST_REF_WAIT;
            end
            dlp_pkg::ST_REF_WAIT: begin
                if (cnt == '0) begin
                    if (pd_ack && pd_req) begin
                        // back into power-down after the refresh
                        next_cke = 1'b0;
                        next_cnt = dlp_pkg::CNT_W'(dlp_pkg::CKE_CYC);
                        next_state = dlp_pkg::ST_PD_ENTER;
                    end else begin
                        // refresh interlude releases ack only on request drop
                        next_pd_ack = 1'b0;
                        next_state = dlp_pkg::ST_IDLE;
                    end
                end
            end
            dlp_pkg::ST_SR_ENTER: begin
                if (cnt == '0) begin
                    next_sr_ack = 1'b1;
                    next_state = dlp_pkg::ST_SR;
                end
            end
            dlp_pkg::ST_SR: begin
                // exit only on request drop; memory refreshes itself
                if (!sr_req) begin
                    next_cke = 1'b1;
                    next_cnt = dlp_pkg::CNT_W'(dlp_pkg::XS_CYC);
                    next_state = dlp_pkg::ST_SR_EXIT;
                end
            end
            dlp_pkg::ST_SR_EXIT: begin
                if (cnt == '0) begin
                    // ack falls after the memory has left
                    next_sr_ack = 1'b0;
                    next_refi_cnt = dlp_pkg::CNT_W'(REFI_CYCLES);
                    next_state = dlp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = dlp_pkg::ST_IDLE;
            end
        endcase
        if (state == dlp_pkg::ST_SR || state == dlp_pkg::ST_SR_ENTER) begin
            next_refi_cnt = refi_cnt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= dlp_pkg::ST_INIT;
            cnt <= dlp_pkg::CNT_W'(INIT_CYCLES);
            refi_cnt <= dlp_pkg::CNT_W'(REFI_CYCLES);
            cmd <= dlp_pkg::CMD_DESEL;
            cke <= 1'b0;
            mem_rst_n <= 1'b0;
            init_done <= 1'b0;
            pd_ack <= 1'b0;
            sr_ack <= 1'b0;
            ref_ack <= 1'b0;
            addr <= '0;
            wdata <= '0;
            be <= '0;
            dq_out <= '0;
            bmask <= '1;
            dq_oe_n <= 1'b1;
            dqs_out <= 1'b0;
            odt <= 1'b0;
            rdata <= '0;
            rvalid <= 1'b0;
            rbeat <= 1'b0;
            mclk <= 1'b0;
            drv_hist <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            refi_cnt <= next_refi_cnt;
            cmd <= next_cmd;
            cke <= next_cke;
            mem_rst_n <= next_mem_rst_n;
            init_done <= next_init_done;
            pd_ack <= next_pd_ack;
            sr_ack <= next_sr_ack;
            ref_ack <= next_ref_ack;
            addr <= next_addr;
            wdata <= next_wdata;
            be <= next_be;
            dq_out <= next_dq_out;
            bmask <= next_bmask;
            dq_oe_n <= next_dq_oe_n;
            dqs_out <= next_dqs_out;
            odt <= next_odt;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            rbeat <= next_rbeat;
            mclk <= next_mclk;
            drv_hist <= next_drv_hist;
        end
    end

    // ------------
    // outputs
    // ------------
    assign o_rdata = rdata;
    assign o_rdata_valid = rvalid;
    assign o_init_done = init_done;
    assign o_refresh_ack = ref_ack;
    assign o_powerdn_ack = pd_ack;
    assign o_self_rfsh_ack = sr_ack;
    assign o_dram_clk = mclk;
    assign o_dram_clk_n = ~mclk;
    assign o_dram_cke = cke;
    assign {o_dram_cs_n, o_dram_ras_n, o_dram_cas_n, o_dram_we_n} = cmd;
    assign o_dram_a = addr[ADDR_W-1:0];
    assign o_dram_ba = addr[ADDR_W+BA_W-1:ADDR_W];
    assign o_dram_odt = odt;
    assign o_dram_reset_n = mem_rst_n;
    assign o_dram_byte_mask = bmask;
    assign o_dram_dq = dq_out;
    assign o_dram_dq_oe_n = dq_oe_n;
    assign o_dram_dqs = dqs_out;
    assign o_dram_dqs_oe_n = dq_oe_n;
    assign o_dram_dqs_n = ~dqs_out;
    assign o_dram_dqs_n_oe_n = dq_oe_n;

endmodule // dlp_ctrl

`default_nettype wire

// file: dv/dlp_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dlp_chk #(
    parameter int DQ_W = 16
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // local side
    input wire logic i_write_req,
    input wire logic i_powerdn_req,
    input wire logic i_self_rfsh_req,
    input wire logic [2*DQ_W-1:0] i_wdata,
    input wire logic [DQ_W/4-1:0] i_be,
    input wire logic o_ready,
    input wire logic o_refresh_ack,
    input wire logic o_powerdn_ack,
    input wire logic o_self_rfsh_ack,
    // memory pins
    input wire logic o_dram_cke,
    input wire logic o_dram_cs_n,
    input wire logic o_dram_ras_n,
    input wire logic o_dram_cas_n,
    input wire logic o_dram_we_n,
    input wire logic o_dram_odt,
    input wire logic [DQ_W/8-1:0] o_dram_byte_mask,
    input wire logic [DQ_W-1:0] o_dram_dq,
    input wire logic o_dram_dq_oe_n,
    input wire logic o_dram_dqs
);
    logic [3:0] cmd;
    assign cmd = {o_dram_cs_n, o_dram_ras_n, o_dram_cas_n, o_dram_we_n};
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    chk_ref_single: assert property (o_refresh_ack |=> !o_refresh_ack)
        else $error("refresh ack longer than one cycle");
    chk_ref_cmd: assert property (o_refresh_ack |->
        (cmd == dlp_pkg::CMD_REF || $past(cmd) == dlp_pkg::CMD_REF))
        else $error("refresh ack without refresh command");
    chk_wr_beats: assert property (o_ready && i_write_req |->
        ##1 (cmd == dlp_pkg::CMD_WR && o_dram_odt)
        ##1 (!o_dram_dq_oe_n && o_dram_dqs && o_dram_dq == $past(i_wdata[DQ_W-1:0], 2))
        ##1 (!o_dram_dq_oe_n && !o_dram_dqs && o_dram_dq == $past(i_wdata[2*DQ_W-1:DQ_W], 3)))
        else $error("write beats wrong");
    chk_wr_mask: assert property (o_ready && i_write_req |->
        ##2 (o_dram_byte_mask == ~$past(i_be[DQ_W/8-1:0], 2))
        ##1 (o_dram_byte_mask == ~$past(i_be[DQ_W/4-1:DQ_W/8], 3)))
        else $error("byte mask wrong");
    chk_no_rw_lowpwr: assert property ((o_powerdn_ack || o_self_rfsh_ack || !o_dram_cke)
        |-> (cmd != dlp_pkg::CMD_RD && cmd != dlp_pkg::CMD_WR))
        else $error("access while in low power");
    chk_ready_block: assert property ((i_powerdn_req || i_self_rfsh_req) |-> !o_ready)
        else $error("ready during low-power request");
    chk_pd_enter: assert property ($rose(o_powerdn_ack) |-> !o_dram_cke && $past(i_powerdn_req))
        else $error("power-down ack rose wrongly");
    chk_pd_exit: assert property ($fell(o_powerdn_ack) |-> o_dram_cke && !$past(i_powerdn_req))
        else $error("power-down ack fell wrongly");
    chk_sr_enter: assert property ($rose(o_self_rfsh_ack) |-> !o_dram_cke && $past(i_self_rfsh_req))
        else $error("self-refresh ack rose wrongly");
    chk_sr_exit: assert property ($fell(o_self_rfsh_ack) |->
        o_dram_cke && $past(o_dram_cke, 8) && !$past(i_self_rfsh_req))
        else $error("self-refresh ack fell before exit");
endmodule // dlp_chk
bind dlp_ctrl dlp_chk #(.DQ_W(DQ_W)) u_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_write_req(i_write_req),
    .i_powerdn_req(i_powerdn_req), .i_self_rfsh_req(i_self_rfsh_req), .i_wdata(i_wdata),
    .i_be(i_be), .o_ready(o_ready), .o_refresh_ack(o_refresh_ack),
    .o_powerdn_ack(o_powerdn_ack), .o_self_rfsh_ack(o_self_rfsh_ack), .o_dram_cke(o_dram_cke),
    .o_dram_cs_n(o_dram_cs_n), .o_dram_ras_n(o_dram_ras_n), .o_dram_cas_n(o_dram_cas_n),
    .o_dram_we_n(o_dram_we_n), .o_dram_odt(o_dram_odt), .o_dram_byte_mask(o_dram_byte_mask),
    .o_dram_dq(o_dram_dq), .o_dram_dq_oe_n(o_dram_dq_oe_n), .o_dram_dqs(o_dram_dqs));
`default_nettype wire

// file: dv/dlp_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module dlp_mem_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // read latency in cycles
    input wire logic [3:0] i_lat,
    // pins from the controller
    input wire logic [3:0] i_cmd,
    input wire logic [1:0] i_a,
    input wire logic [1:0] i_mask,
    input wire logic [15:0] i_dq,
    // read drive back
    output logic [15:0] o_dq,
    output logic o_dqs
);
    logic [31:0] mem [4];
    logic [1:0] wa;
    logic [1:0] ra;
    logic [1:0] wph;
    logic [2:0] rph;
    logic [4:0] rcnt;
    logic [15:0] last;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wph <= 2'h0;
            rph <= 3'h0;
            rcnt <= 5'h0;
            last <= 16'h0;
        end else begin
            if (i_cmd == dlp_pkg::CMD_WR) begin
                wa <= i_a;
                wph <= 2'h1;
            end else if (wph != 2'h0) begin
                // masked bytes keep their old contents
                for (int b = 0; b < 2; b++) begin
                    if (!i_mask[b]) mem[wa][((wph == 2'h2) ? 16 : 0) + b*8 +: 8] <= i_dq[b*8 +: 8];
                end
                wph <= (wph == 2'h1) ? 2'h2 : 2'h0;
            end
            if (i_cmd == dlp_pkg::CMD_RD) begin
                ra <= i_a;
                rcnt <= {1'b0, i_lat} + 5'h1;
            end else if (rcnt != 5'h0) begin
                rcnt <= rcnt - 5'h1;
                if (rcnt == 5'h1) rph <= 3'h1;
            end else if (rph != 3'h0) begin
                rph <= (rph == 3'h4) ? 3'h0 : rph + 3'h1;
            end
            if (rph != 3'h0) last <= o_dq;
        end
    end
    // released bus shows the inverse; strobe parks low so no stray rise
    always_comb begin
        o_dqs = (rph != 3'h0) && rph[0];
        o_dq = ~last;
        if (rph != 3'h0) o_dq = (rph >= 3'h3) ? mem[ra][31:16] : mem[ra][15:0];
    end
endmodule // dlp_mem_model
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int INIT_N = 20;
    localparam int REFI_N = 50;
    logic clk, nrst, rd_req, wr_req, pd_req, sr_req, ready, rvalid, init_done, ref_ack;
    logic pd_ack, sr_ack, cke, cs_n, ras_n, cas_n, we_n, mrst_n, mdqs;
    logic dq_oe_n, dqs_o, dqs_oe_n, dqsn_o, dqsn_oe_n, dqs_i, dqsn_i;
    logic [15:0] addr, dq_o, dq_i, mdq;
    logic [31:0] wdata, rdata;
    logic [3:0] be, lat;
    logic [12:0] dram_a;
    logic [1:0] mask;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    assign dq_i = dq_oe_n ? mdq : dq_o;
    assign dqs_i = dqs_oe_n ? mdqs : dqs_o;
    assign dqsn_i = dqsn_oe_n ? ~mdqs : dqsn_o;
    dlp_ctrl #(.INIT_CYCLES(INIT_N), .REFI_CYCLES(REFI_N)) dut (
        .i_core_clk(clk), .i_nrst(nrst), .i_read_req(rd_req), .i_write_req(wr_req),
        .i_addr(addr), .i_wdata(wdata), .i_be(be), .o_ready(ready), .o_rdata(rdata),
        .o_rdata_valid(rvalid), .o_init_done(init_done), .o_refresh_ack(ref_ack),
        .i_powerdn_req(pd_req), .o_powerdn_ack(pd_ack), .i_self_rfsh_req(sr_req),
        .o_self_rfsh_ack(sr_ack), .o_dram_clk(), .o_dram_clk_n(), .o_dram_cke(cke),
        .o_dram_cs_n(cs_n), .o_dram_ras_n(ras_n), .o_dram_cas_n(cas_n), .o_dram_we_n(we_n),
        .o_dram_a(dram_a), .o_dram_ba(), .o_dram_odt(), .o_dram_reset_n(mrst_n),
        .o_dram_byte_mask(mask), .i_dram_dq(dq_i), .o_dram_dq(dq_o), .o_dram_dq_oe_n(dq_oe_n),
        .i_dram_dqs(dqs_i), .o_dram_dqs(dqs_o), .o_dram_dqs_oe_n(dqs_oe_n),
        .i_dram_dqs_n(dqsn_i), .o_dram_dqs_n(dqsn_o), .o_dram_dqs_n_oe_n(dqsn_oe_n));
    dlp_mem_model u_mem (.i_core_clk(clk), .i_nrst(nrst), .i_lat(lat),
        .i_cmd({cs_n, ras_n, cas_n, we_n}), .i_a(dram_a[1:0]), .i_mask(mask), .i_dq(dq_o),
        .o_dq(mdq), .o_dqs(mdqs));
    // ------------
    // helpers
    // ------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // request held until an edge samples ready high
    task automatic req(input logic wr, input logic [15:0] a, input logic [31:0] d,
            input logic [3:0] b);
        int n;
        logic taken;
        n = 0;
        taken = 1'b0;
        addr = a;
        wdata = d;
        be = b;
        wr_req = wr;
        rd_req = !wr;
        while (!taken && n < 300) begin
            taken = (ready === 1'b1);
            tick();
            n++;
        end
        wr_req = 1'b0;
        rd_req = 1'b0;
        tick();
        check("request taken", {31'h0, taken}, 32'h1);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        int n;
        req(1'b0, a, 32'h0, 4'h0);
        n = 0;
        while (rvalid !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        check("read word", rdata, exp);
    endtask
    // ------------
    // scenarios
    // ------------
    task automatic t_write_read();
        lat = 4'h0;
        req(1'b1, 16'h0001, 32'hA5C3_1E7F, 4'hF);
        req(1'b1, 16'h0002, 32'h1234_5678, 4'hF);
        req(1'b1, 16'h0002, 32'hFFFF_FFFF, 4'h9);
        rd_chk(16'h0001, 32'hA5C3_1E7F);
        lat = 4'h9;
        rd_chk(16'h0002, 32'hFF34_56FF);
    endtask
    task automatic t_powerdown();
        int n, refs, bad;
        pd_req = 1'b1;
        n = 0;
        while (pd_ack !== 1'b1 && n < 40) begin tick(); n++; end
        check("pd ack", {31'h0, pd_ack}, 32'h1);
        check("pd cke", {31'h0, cke}, 32'h0);
        wr_req = 1'b1;
        refs = 0;
        bad = 0;
        repeat (3*REFI_N) begin
            tick();
            refs += (ref_ack === 1'b1);
            bad += (pd_ack !== 1'b1) || (ready !== 1'b0);
        end
        wr_req = 1'b0;
        check("pd refreshes", refs >= 2, 1);
        check("pd ack held", bad, 0);
        pd_req = 1'b0;
        n = 0;
        while (pd_ack !== 1'b0 && n < 40) begin tick(); n++; end
        check("pd ack drop", {31'h0, pd_ack}, 32'h0);
        check("pd exit cke", {31'h0, cke}, 32'h1);
    endtask
    task automatic t_selfrefresh();
        int n, bad, hi;
        // request held for the whole stay
        sr_req = 1'b1;
        n = 0;
        while (sr_ack !== 1'b1 && n < 40) begin tick(); n++; end
        check("sr ack", {31'h0, sr_ack}, 32'h1);
        bad = 0;
        repeat (2*REFI_N) begin
            tick();
            bad += (cke !== 1'b0) || (sr_ack !== 1'b1) || (ref_ack !== 1'b0);
        end
        check("sr held", bad, 0);
        sr_req = 1'b0;
        n = 0;
        hi = 0;
        while (sr_ack !== 1'b0 && n < 60) begin
            tick();
            n++;
            hi += (cke === 1'b1);
        end
        check("sr ack drop", {31'h0, sr_ack}, 32'h0);
        check("sr exit wait", hi >= dlp_pkg::XS_CYC, 1);
    endtask
    // ------------
    // clock, watchdog and main sequence
    // ------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        int n;
        nrst = 1'b0;
        {rd_req, wr_req, pd_req, sr_req} = 4'h0;
        addr = 16'h0;
        wdata = 32'h0;
        be = 4'h0;
        lat = 4'h0;
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        n = 0;
        while (init_done !== 1'b1 && n < 200) begin tick(); n++; end
        check("memory reset", {31'h0, mrst_n}, 32'h1);
        t_write_read();
        t_powerdown();
        t_selfrefresh();
        // contents survive both low-power states
        rd_chk(16'h0001, 32'hA5C3_1E7F);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
